// ===== bst_btn_model.sv
// Model of the push buttons and the sync pulse source
`timescale 1ns/1ps
`default_nettype none
module bst_btn_model (
  input wire logic i_clk, // Clock
  input wire logic i_left, // Wanted left level
  input wire logic i_right, // Wanted right level
  input wire logic i_sync, // Wanted sync level
  output logic o_left, // Left pin
  output logic o_right, // Right pin
  output logic o_sync // Sync pin
);
  // ==========================================================
  // Contacts chatter back for one cycle after each change
  logic [1:0] l_q = 2'h0;
  logic [1:0] r_q = 2'h0;
  always_ff @(posedge i_clk) begin
    l_q <= {l_q[0], i_left};
    r_q <= {r_q[0], i_right};
  end
  assign o_left = i_left ^ l_q[0] ^ l_q[1];
  assign o_right = i_right ^ r_q[0] ^ r_q[1];
  // Sync source is electronic and clean
  assign o_sync = i_sync;
endmodule
`default_nettype wire

// ===== bst_checker.sv
// Assertion checker for the button and sync trigger block
`timescale 1ns/1ps
`default_nettype none
module bst_checker
  import bst_pkg::*;
#(
  parameter int unsigned CLK_PER_US_P = CLK_PER_US,
  parameter int unsigned HOME_HOLD_US_P = HOME_HOLD_US
) (
  input wire logic I_CLK, // Clock
  input wire logic I_RST_N, // Reset
  input wire logic I_AVS_READ, // Read
  input wire logic I_AVS_WRITE, // Write
  input wire logic [31:0] O_AVS_READDATA, // Read data
  input wire logic O_AVS_WAITREQUEST, // Stall
  input wire logic I_BTN_LEFT, // Left pin
  input wire logic I_BTN_RIGHT, // Right pin
  input wire logic O_CMD_VALID, // Strobe
  input wire bst_cmd_type O_CMD // Command
);
  // ==========================================================
  // Helper: cycles both button pins have sat at one level
  int unsigned same_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      same_q <= 0;
    end else if (I_BTN_LEFT != I_BTN_RIGHT) begin
      same_q <= 0;
    end else if (same_q < 32'hfffff) begin
      same_q <= same_q + 1;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  // Command port timing and content
  a_strobe_single: assert property (O_CMD_VALID |=> !O_CMD_VALID)
    else $error("command strobe longer than one cycle");
  a_cmd_held: assert property ($changed(O_CMD) |-> O_CMD_VALID)
    else $error("command changed without strobe");
  a_kind_onehot: assert property (O_CMD_VALID |-> $onehot(O_CMD.kind))
    else $error("command kind not one-hot");
  a_home_after_hold: assert property (O_CMD_VALID && O_CMD.kind == CMD_HOME
    |-> same_q >= HOME_HOLD_US_P * CLK_PER_US_P)
    else $error("home issued before hold time");
  a_stop_then_home: assert property (O_CMD_VALID && O_CMD.kind == CMD_HOME
    |-> $past(O_CMD.kind) == CMD_STOP_DECEL)
    else $error("home not preceded by stop");
  a_reset_quiet: assert property ($rose(I_RST_N) |-> !O_CMD_VALID [*2])
    else $error("command right after reset");
  // Register bus answer
  a_wait_one: assert property ($rose(I_AVS_READ) || $rose(I_AVS_WRITE)
    |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("bus answer not in second cycle");
  a_wait_req: assert property (O_AVS_WAITREQUEST |-> I_AVS_READ || I_AVS_WRITE)
    else $error("stall without request");
  a_rdata_read: assert property ($changed(O_AVS_READDATA) |-> $past(I_AVS_READ))
    else $error("read data moved without read");
endmodule

bind bst_trigger bst_checker #(
  .CLK_PER_US_P(CLK_PER_US_P),
  .HOME_HOLD_US_P(HOME_HOLD_US_P)
) u_chk (
  .I_CLK(I_CLK),
  .I_RST_N(I_RST_N),
  .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .I_BTN_LEFT(I_BTN_LEFT),
  .I_BTN_RIGHT(I_BTN_RIGHT),
  .O_CMD_VALID(O_CMD_VALID),
  .O_CMD(O_CMD)
);
`default_nettype wire

// ===== bst_pkg.sv
// Package with constants, types and register map of the button and sync trigger block
package bst_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned DEBOUNCE_MS = 3;
  localparam int unsigned DEBOUNCE_US = DEBOUNCE_MS * 1000;
  localparam int unsigned HOME_HOLD_S = 3;
  localparam int unsigned HOME_HOLD_US = HOME_HOLD_S * 1_000_000;
  localparam int unsigned SPEED_ENTRIES = 10;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CLICK_TIME = 8'h04;
  localparam logic [7:0] REG_CLICK_STEPS = 8'h08;
  localparam logic [7:0] REG_CLICK_USTEPS = 8'h0c;
  localparam logic [7:0] REG_SYNC_MIN_US = 8'h10;
  localparam logic [7:0] REG_SYNC_STEPS = 8'h14;
  localparam logic [7:0] REG_SYNC_USTEPS = 8'h18;
  localparam logic [7:0] REG_SYNC_SPEED = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_SPEED_BASE = 8'h40;
  localparam logic [7:0] REG_HOLD_BASE = 8'h80;

  // ==========================================================================
  // Control field positions and reset value
  localparam int unsigned CTRL_BTN_ACT_HIGH = 0;
  localparam int unsigned CTRL_INV_LEFT = 1;
  localparam int unsigned CTRL_INV_RIGHT = 2;
  localparam int unsigned CTRL_SYNC_EN = 3;
  localparam int unsigned CTRL_SYNC_INV_LVL = 4;
  localparam int unsigned CTRL_SYNC_INV_EDGE = 5;
  localparam logic [5:0] CTRL_RESET = 6'h01;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [23:0] steps;
    logic [7:0] usteps;
  } bst_speed_type;

  typedef enum logic [3:0] {
    CMD_MOVE_REL = 4'b0001,
    CMD_RUN = 4'b0010,
    CMD_STOP_DECEL = 4'b0100,
    CMD_HOME = 4'b1000
  } bst_cmd_kind_type;

  typedef struct packed {
    bst_cmd_kind_type kind;
    logic dir_right;
    logic append;
    logic [31:0] steps;
    logic [7:0] usteps;
    bst_speed_type speed;
  } bst_cmd_type;

  typedef enum logic [4:0] {
    BS_IDLE = 5'b00001,
    BS_PRESS = 5'b00010,
    BS_HOLD = 5'b00100,
    BS_BOTH = 5'b01000,
    BS_HOMED = 5'b10000
  } bst_btn_state_type;

endpackage

// ===== bst_tb.sv
// Self-checking testbench for the button and sync trigger block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bst_pkg::*;
  // ==========================================================
  // Stimulus, observed signals and counters
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic host = 1'b0, done = 1'b0, lp = 1'b1, rp = 1'b0, sp = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic bl, br, bs, wreq, cv;
  logic [31:0] rdat;
  bst_cmd_type cmd, c;
  bst_cmd_type q[$];
  int err_total = 0;
  int n_checks = 0;
  always #10 clk = ~clk;

  bst_trigger #(.CLK_PER_US_P(2), .DEBOUNCE_US_P(3), .HOME_HOLD_US_P(20)) DUT (
    .I_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq), .I_BTN_LEFT(bl),
    .I_BTN_RIGHT(br), .I_SYNC_IN(bs), .I_HOST_CMD(host), .I_MOVE_DONE(done),
    .O_CMD_VALID(cv), .O_CMD(cmd));
  bst_btn_model PM (.i_clk(clk), .i_left(lp), .i_right(rp), .i_sync(sp),
    .o_left(bl), .o_right(br), .o_sync(bs));

  // Collect each command at the edge closing its strobe cycle
  always @(posedge clk) begin
    if (cv === 1'b1) begin
      q.push_back(cmd);
    end
  end

  // Compare and count
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Bus cycles, request held until stall is seen low
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    chk(rdat, e);
  endtask
  // Wait for the next command and compare what its kind defines
  task automatic ek(input bst_cmd_kind_type k, input logic [41:0] v);
    int n;
    n = 0;
    while (q.size() == 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    c = (q.size() > 0) ? q.pop_front() : '0;
    chk(c.kind, k);
    if (k == CMD_MOVE_REL) chk({c.dir_right, c.append, c.steps, c.usteps}, v);
    if (k == CMD_RUN) chk({c.dir_right, c.speed}, v[32:0]);
  endtask
  task automatic nocmd(input int n);
    repeat (n) @(posedge clk);
    chk(q.size(), 0);
    q.delete();
  endtask
  // Pin and strobe drivers
  task automatic btn(input logic l, input logic r, input int n);
    @(posedge clk);
    lp <= l;
    rp <= r;
    repeat (n) @(posedge clk);
  endtask
  task automatic pls(input int n);
    @(posedge clk);
    sp <= 1'b1;
    repeat (n) @(posedge clk);
    sp <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic mvdone(input logic h);
    @(posedge clk);
    host <= h;
    done <= !h;
    @(posedge clk);
    host <= 1'b0;
    done <= 1'b0;
  endtask
  task automatic tend(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence: left pin already active through reset
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ek(CMD_RUN, {1'b0, 32'h0});
    btn(1'b0, 1'b0, 0);
    ek(CMD_STOP_DECEL, 0);
    rchk(REG_CTRL, 32'h1);
    rchk(8'hfc, 32'h0);
    rchk(REG_HOLD_BASE + 8'h24, 32'h0);
    bw(REG_CLICK_TIME, 32'h1e);
    bw(REG_CLICK_STEPS, 32'h123);
    bw(REG_CLICK_USTEPS, 32'h5);
    for (int i = 0; i < 3; i++) begin
      bw(REG_SPEED_BASE + 8'(4 * i), 32'h100 * (i + 1) + i);
      bw(REG_HOLD_BASE + 8'(4 * i), 32'ha);
    end
    rchk(REG_SPEED_BASE + 8'h8, 32'h302);
    tend("registers");
    for (int d = 0; d < 2; d++) begin
      btn(!d[0], d[0], 15);
      btn(1'b0, 1'b0, 0);
      ek(CMD_MOVE_REL, {d[0], 1'b0, 32'h123, 8'h05});
    end
    btn(1'b0, 1'b1, 0);
    ek(CMD_RUN, {1'b1, 32'h100});
    ek(CMD_RUN, {1'b1, 32'h201});
    ek(CMD_RUN, {1'b1, 32'h302});
    nocmd(100);
    btn(1'b0, 1'b0, 0);
    ek(CMD_STOP_DECEL, 0);
    btn(1'b1, 1'b1, 0);
    ek(CMD_STOP_DECEL, 0);
    ek(CMD_HOME, 0);
    btn(1'b0, 1'b0, 0);
    nocmd(40);
    rchk(REG_STATUS, 32'h120);
    tend("buttons");
    bw(REG_CTRL, 32'h0);
    btn(1'b1, 1'b1, 30);
    nocmd(1);
    btn(1'b0, 1'b1, 15);
    btn(1'b1, 1'b1, 0);
    ek(CMD_MOVE_REL, {1'b0, 1'b0, 32'h123, 8'h05});
    btn(1'b0, 1'b0, 0);
    bw(REG_CTRL, 32'h1);
    nocmd(30);
    bw(REG_CTRL, 32'h3);
    repeat (15) @(posedge clk);
    bw(REG_CTRL, 32'h1);
    ek(CMD_MOVE_REL, {1'b0, 1'b0, 32'h123, 8'h05});
    btn(1'b1, 1'b0, 2);
    btn(1'b0, 1'b0, 30);
    nocmd(1);
    tend("levels");
    bw(REG_SYNC_STEPS, 32'h40);
    bw(REG_SYNC_USTEPS, 32'h7);
    bw(REG_SYNC_SPEED, 32'h500);
    pls(4);
    nocmd(1);
    bw(REG_CTRL, 32'h9);
    pls(4);
    ek(CMD_MOVE_REL, {1'b1, 1'b0, 32'h40, 8'h07});
    chk(c.speed, 32'h500);
    bw(REG_SYNC_STEPS, 32'h41);
    pls(4);
    ek(CMD_MOVE_REL, {1'b1, 1'b1, 32'h41, 8'h07});
    mvdone(1'b1);
    pls(4);
    ek(CMD_MOVE_REL, {1'b1, 1'b0, 32'h41, 8'h07});
    mvdone(1'b0);
    bw(REG_SYNC_MIN_US, 32'h5);
    pls(4);
    nocmd(1);
    pls(20);
    ek(CMD_MOVE_REL, {1'b1, 1'b0, 32'h41, 8'h07});
    mvdone(1'b0);
    bw(REG_CTRL, 32'h19);
    nocmd(30);
    bw(REG_CTRL, 32'h29);
    @(posedge clk);
    sp <= 1'b1;
    nocmd(30);
    @(posedge clk);
    sp <= 1'b0;
    ek(CMD_MOVE_REL, {1'b1, 1'b0, 32'h41, 8'h07});
    tend("sync");
    finish_test();
  end

  // Watchdog against a hung run
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire

// ===== bst_trigger.sv
// Button and sync input motion trigger with Avalon-MM register slave
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module bst_trigger
  import bst_pkg::*;
#(
  parameter int unsigned CLK_PER_US_P = CLK_PER_US,
  parameter int unsigned DEBOUNCE_US_P = DEBOUNCE_US,
  parameter int unsigned HOME_HOLD_US_P = HOME_HOLD_US
) (
  input wire logic I_CLK, // System clock
  input wire logic I_RST_N, // Async reset, active low
  input wire logic [7:0] I_AVS_ADDRESS, // Byte address
  input wire logic I_AVS_READ, // Read request
  input wire logic I_AVS_WRITE, // Write request
  input wire logic [31:0] I_AVS_WRITEDATA, // Write data
  input wire logic [3:0] I_AVS_BYTEENABLE, // Byte lanes
  output logic [31:0] O_AVS_READDATA, // Read data
  output logic O_AVS_WAITREQUEST, // Stall
  input wire logic I_BTN_LEFT, // Left button pin
  input wire logic I_BTN_RIGHT, // Right button pin
  input wire logic I_SYNC_IN, // Sync input pin
  input wire logic I_HOST_CMD, // Host motion command pulse
  input wire logic I_MOVE_DONE, // Motion engine finished pulse
  output logic O_CMD_VALID, // Command strobe
  output bst_cmd_type O_CMD // Command to motion engine
);

  // ==========================================================================
  // Registers
  logic [5:0] ctrl_q;
  logic [31:0] click_time_q;
  logic [31:0] click_steps_q;
  logic [7:0] click_usteps_q;
  logic [31:0] sync_min_q;
  logic [31:0] sync_steps_q;
  logic [7:0] sync_usteps_q;
  bst_speed_type sync_speed_q;
  bst_speed_type speed_tab_q [SPEED_ENTRIES];
  logic [31:0] hold_us_q [SPEED_ENTRIES];
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] status;
  logic [1:0] pressed_q;
  logic sync_lvl_active;
  logic sync_move_q;
  logic [3:0] idx_q;
  bst_btn_state_type state_q;

  // Table decode: hit flag and entry index for a base offset
  function automatic logic tab_hit(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] rel;
    rel = addr - base;
    tab_hit = (addr >= base) && (rel[7:2] < 6'(SPEED_ENTRIES)) && (rel[1:0] == 2'b00);
  endfunction

  function automatic logic [3:0] tab_idx(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] rel;
    rel = addr - base;
    tab_idx = rel[5:2];
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // ==========================================================================
  // Bus handshake: one wait cycle, then the answer
  logic req;
  logic wr_now;
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign wr_now = I_AVS_WRITE & ack_q;
  assign O_AVS_WAITREQUEST = req & ~ack_q;
  assign O_AVS_READDATA = rdata_q;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Status word shows live block state
  assign status = {19'h0, state_q, idx_q, sync_move_q, sync_lvl_active, pressed_q};

  // Read data captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q <= WORD_RESET;
    end else if (I_AVS_READ && !ack_q) begin
      rdata_q <= WORD_RESET;
      case (I_AVS_ADDRESS)
        REG_CTRL: rdata_q <= {26'h0, ctrl_q};
        REG_CLICK_TIME: rdata_q <= click_time_q;
        REG_CLICK_STEPS: rdata_q <= click_steps_q;
        REG_CLICK_USTEPS: rdata_q <= {24'h0, click_usteps_q};
        REG_SYNC_MIN_US: rdata_q <= sync_min_q;
        REG_SYNC_STEPS: rdata_q <= sync_steps_q;
        REG_SYNC_USTEPS: rdata_q <= {24'h0, sync_usteps_q};
        REG_SYNC_SPEED: rdata_q <= sync_speed_q;
        REG_STATUS: rdata_q <= status;
        default: begin
          if (tab_hit(I_AVS_ADDRESS, REG_SPEED_BASE)) begin
            rdata_q <= speed_tab_q[tab_idx(I_AVS_ADDRESS, REG_SPEED_BASE)];
          end else if (tab_hit(I_AVS_ADDRESS, REG_HOLD_BASE)) begin
            rdata_q <= hold_us_q[tab_idx(I_AVS_ADDRESS, REG_HOLD_BASE)];
          end
        end
      endcase
    end
  end

  // Scalar settings registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_q <= CTRL_RESET;
      click_time_q <= WORD_RESET;
      click_steps_q <= WORD_RESET;
      click_usteps_q <= 8'h00;
      sync_min_q <= WORD_RESET;
      sync_steps_q <= WORD_RESET;
      sync_usteps_q <= 8'h00;
      sync_speed_q <= WORD_RESET;
    end else if (wr_now) begin
      case (I_AVS_ADDRESS)
        REG_CTRL: ctrl_q <= 6'(merge({26'h0, ctrl_q}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
        REG_CLICK_TIME: click_time_q <= merge(click_time_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        REG_CLICK_STEPS: click_steps_q <= merge(click_steps_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        REG_CLICK_USTEPS: click_usteps_q <= I_AVS_BYTEENABLE[0] ? I_AVS_WRITEDATA[7:0] : click_usteps_q;
        REG_SYNC_MIN_US: sync_min_q <= merge(sync_min_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        REG_SYNC_STEPS: sync_steps_q <= merge(sync_steps_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        REG_SYNC_USTEPS: sync_usteps_q <= I_AVS_BYTEENABLE[0] ? I_AVS_WRITEDATA[7:0] : sync_usteps_q;
        REG_SYNC_SPEED: sync_speed_q <= merge(sync_speed_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        default: ;
      endcase
    end
  end

  // Speed table and hold interval table
  generate
    for (genvar e = 0; e < SPEED_ENTRIES; e++) begin : g_tab
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          speed_tab_q[e] <= WORD_RESET;
          hold_us_q[e] <= WORD_RESET;
        end else if (wr_now) begin
          if (tab_hit(I_AVS_ADDRESS, REG_SPEED_BASE) &&
              tab_idx(I_AVS_ADDRESS, REG_SPEED_BASE) == 4'(e)) begin
            speed_tab_q[e] <= merge(speed_tab_q[e], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
          end
          if (tab_hit(I_AVS_ADDRESS, REG_HOLD_BASE) &&
              tab_idx(I_AVS_ADDRESS, REG_HOLD_BASE) == 4'(e)) begin
            hold_us_q[e] <= merge(hold_us_q[e], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Microsecond tick from the system clock
  logic [7:0] div_q;
  logic us_tick;
  assign us_tick = (div_q == 8'(CLK_PER_US_P - 1));

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_q <= 8'h00;
    end else begin
      div_q <= us_tick ? 8'h00 : div_q + 8'h01;
    end
  end

  // ==========================================================================
  // Pin synchronisers: index 0 left, 1 right, 2 sync
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {I_SYNC_IN, I_BTN_RIGHT, I_BTN_LEFT};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ==========================================================================
  // Button debounce; the press follows the active state whatever made it active
  logic [1:0] btn_inv;
  assign btn_inv = {ctrl_q[CTRL_INV_RIGHT], ctrl_q[CTRL_INV_LEFT]};

  generate
    for (genvar b = 0; b < 2; b++) begin : g_btn
      logic active;
      logic [31:0] db_q;
      assign active = pin_s2_q[b] ^ ~ctrl_q[CTRL_BTN_ACT_HIGH] ^ btn_inv[b];
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          db_q <= WORD_RESET;
          pressed_q[b] <= 1'b0;
        end else if (active == pressed_q[b]) begin
          db_q <= WORD_RESET;
        end else if (db_q > DEBOUNCE_US_P) begin
          pressed_q[b] <= active;
          db_q <= WORD_RESET;
        end else if (us_tick) begin
          db_q <= db_q + 32'h1;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Button state machine
  logic [31:0] tmr_q;
  logic btn_fire_q;
  bst_cmd_type btn_cmd_q;
  logic both;
  logic none;
  logic [3:0] idx_nx;
  logic can_step;
  assign both = &pressed_q;
  assign none = ~|pressed_q;
  assign idx_nx = idx_q + 4'h1;
  assign can_step = (idx_q < 4'(SPEED_ENTRIES - 1)) && (hold_us_q[idx_q] != WORD_RESET) &&
                    (speed_tab_q[idx_nx] != WORD_RESET);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= BS_IDLE;
      tmr_q <= WORD_RESET;
      idx_q <= 4'h0;
      btn_fire_q <= 1'b0;
      btn_cmd_q <= '0;
    end else begin
      btn_fire_q <= 1'b0;
      if (us_tick) begin
        tmr_q <= tmr_q + 32'h1;
      end
      case (state_q)
        BS_IDLE: begin
          tmr_q <= WORD_RESET;
          if (both) begin
            btn_fire_q <= 1'b1;
            btn_cmd_q.kind <= CMD_STOP_DECEL;
            state_q <= BS_BOTH;
          end else if (!none) begin
            btn_cmd_q.dir_right <= pressed_q[1];
            state_q <= BS_PRESS;
          end
        end
        BS_PRESS: begin
          if (both) begin
            btn_fire_q <= 1'b1;
            btn_cmd_q.kind <= CMD_STOP_DECEL;
            tmr_q <= WORD_RESET;
            state_q <= BS_BOTH;
          end else if (none) begin
            btn_fire_q <= 1'b1;
            btn_cmd_q.kind <= CMD_MOVE_REL;
            btn_cmd_q.steps <= click_steps_q;
            btn_cmd_q.usteps <= click_usteps_q;
            state_q <= BS_IDLE;
          end else if (tmr_q > click_time_q) begin
            btn_fire_q <= 1'b1;
            btn_cmd_q.kind <= CMD_RUN;
            btn_cmd_q.speed <= speed_tab_q[0];
            idx_q <= 4'h0;
            tmr_q <= WORD_RESET;
            state_q <= BS_HOLD;
          end
        end
        BS_HOLD: begin
          if (both) begin
            btn_fire_q <= 1'b1;
            btn_cmd_q.kind <= CMD_STOP_DECEL;
            tmr_q <= WORD_RESET;
            state_q <= BS_BOTH;
          end else if (none) begin
            btn_fire_q <= 1'b1;
            btn_cmd_q.kind <= CMD_STOP_DECEL;
            state_q <= BS_IDLE;
          end else if (can_step && tmr_q >= hold_us_q[idx_q]) begin
            btn_fire_q <= 1'b1;
            btn_cmd_q.speed <= speed_tab_q[idx_nx];
            idx_q <= idx_nx;
            tmr_q <= WORD_RESET;
          end
        end
        BS_BOTH: begin
          if (!both) begin
            state_q <= BS_HOMED;
          end else if (tmr_q >= HOME_HOLD_US_P) begin
            btn_fire_q <= 1'b1;
            btn_cmd_q.kind <= CMD_HOME;
            state_q <= BS_HOMED;
          end
        end
        BS_HOMED: begin
          if (none) begin
            state_q <= BS_IDLE;
          end
        end
        default: state_q <= BS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Sync input: edge on raw level, level inversion only alters the status
  logic sync_prev_q;
  logic sync_post;
  logic sync_edge;
  logic sync_armed_q;
  logic [31:0] sync_cnt_q;
  logic sync_valid;
  logic sync_fire_q;
  bst_cmd_type sync_cmd_q;
  assign sync_lvl_active = pin_s2_q[2] ^ ctrl_q[CTRL_SYNC_INV_LVL];
  assign sync_post = ~ctrl_q[CTRL_SYNC_INV_EDGE];
  assign sync_edge = (pin_s2_q[2] != sync_prev_q) && (pin_s2_q[2] == sync_post);

  // Pulse length check; zero minimum accepts the edge at once
  always_comb begin
    sync_valid = 1'b0;
    if (sync_edge && sync_min_q == WORD_RESET) begin
      sync_valid = 1'b1;
    end else if (sync_armed_q && pin_s2_q[2] == sync_post && us_tick &&
                 sync_cnt_q + 32'h1 >= sync_min_q) begin
      sync_valid = 1'b1;
    end
  end

  // Previous level resets low so a high input at start counts as an edge
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync_prev_q <= 1'b0;
      sync_armed_q <= 1'b0;
      sync_cnt_q <= WORD_RESET;
    end else begin
      sync_prev_q <= pin_s2_q[2];
      if (sync_edge) begin
        sync_armed_q <= (sync_min_q != WORD_RESET);
        sync_cnt_q <= WORD_RESET;
      end else if (sync_armed_q) begin
        if (pin_s2_q[2] != sync_post || sync_valid) begin
          sync_armed_q <= 1'b0;
        end else if (us_tick) begin
          sync_cnt_q <= sync_cnt_q + 32'h1;
        end
      end
    end
  end

  // Sync command takes a snapshot of the settings at the valid edge
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync_fire_q <= 1'b0;
      sync_cmd_q <= '0;
    end else begin
      sync_fire_q <= sync_valid & ctrl_q[CTRL_SYNC_EN];
      if (sync_valid) begin
        sync_cmd_q.kind <= CMD_MOVE_REL;
        sync_cmd_q.dir_right <= 1'b1;
        sync_cmd_q.append <= sync_move_q;
        sync_cmd_q.steps <= sync_steps_q;
        sync_cmd_q.usteps <= sync_usteps_q;
        sync_cmd_q.speed <= sync_speed_q;
      end
    end
  end

  // Sync move in progress; a newer sync pulse wins over its own clear
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync_move_q <= 1'b0;
    end else if (sync_valid && ctrl_q[CTRL_SYNC_EN]) begin
      sync_move_q <= 1'b1;
    end else if (I_MOVE_DONE || I_HOST_CMD || btn_fire_q) begin
      sync_move_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Command output; sync wins a tie as the most recent source
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CMD_VALID <= 1'b0;
      O_CMD <= '0;
    end else begin
      O_CMD_VALID <= sync_fire_q | btn_fire_q;
      if (sync_fire_q) begin
        O_CMD <= sync_cmd_q;
      end else if (btn_fire_q) begin
        O_CMD <= btn_cmd_q;
      end
    end
  end

endmodule
`default_nettype wire
